// *** logic/ckr_pkg.sv ***
package ckr_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_ALARM_REF  = 8'h07;
	localparam logic [7:0] OFS_STATIC_LVL = 8'h08;
	localparam logic [7:0] OFS_HOLD_AVG   = 8'h09;
	localparam logic [7:0] OFS_OUT_PD     = 8'h0a;
	localparam logic [7:0] OFS_IN_PD      = 8'h0b;
	localparam logic [7:0] OFS_COARSE_PH  = 8'h10;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ALARM_REF  = 8'h00;
	localparam logic [7:0] RST_STATIC_LVL = 8'h00;
	localparam logic [7:0] RST_HOLD_AVG   = 8'hc0;
	localparam logic [7:0] RST_OUT_PD     = 8'h00;
	localparam logic [7:0] RST_IN_PD      = 8'h40;
	localparam logic [7:0] RST_COARSE_PH  = 8'h00;

	// ----------------------------------------------------------------
	// writable bit masks; reserved bits are read-only
	// ----------------------------------------------------------------
	localparam logic [7:0] WM_ALARM_REF  = 8'h07;
	localparam logic [7:0] WM_STATIC_LVL = 8'hf0;
	localparam logic [7:0] WM_HOLD_AVG   = 8'hf8;
	localparam logic [7:0] WM_OUT_PD     = 8'h0c;
	localparam logic [7:0] WM_IN_PD      = 8'h03;
	localparam logic [7:0] WM_COARSE_PH  = 8'hff;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int OUT_TWO_LVL_LSB = 6;
	localparam int OUT_ONE_LVL_LSB = 4;
	localparam int HOLD_AVG_LSB    = 3;
	localparam int OUT_TWO_OFF_BIT = 3;
	localparam int OUT_ONE_OFF_BIT = 2;
	localparam int IN_TWO_OFF_BIT  = 1;
	localparam int IN_ONE_OFF_BIT  = 0;

	// ----------------------------------------------------------------
	// codes
	// ----------------------------------------------------------------
	localparam logic [2:0] REF_SEL_CRYSTAL = 3'h0;
	localparam logic [2:0] REF_SEL_IN_ONE  = 3'h1;
	localparam logic [2:0] REF_SEL_IN_TWO  = 3'h2;
	localparam logic [1:0] LVL_NORMAL      = 2'h0;
	localparam logic [1:0] LVL_LOW         = 2'h1;
	localparam logic [1:0] LVL_HIGH        = 2'h2;
	localparam logic [2:0] HS_DIV_ZERO     = 3'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int PHASE_SETTLE_S = 20;
	localparam int CLK_HZ         = 100_000_000;
	localparam longint PHASE_SETTLE_CYC = longint'(PHASE_SETTLE_S) * longint'(CLK_HZ);

	typedef enum logic [1:0] {
		LV_PASS  = 2'b00,
		LV_WAIT  = 2'b01,
		LV_HOLD  = 2'b11,
		LV_LEAVE = 2'b10
	} ckr_lvl_state_t;

endpackage : ckr_pkg

// *** logic/ckr_level_force.sv ***
`timescale 1ns/1ps
module ckr_level_force
	import ckr_pkg::*;
(
	input  wire logic       clk_i,      // system clock
	input  wire logic       reset_i,    // sync reset, active high
	input  wire logic       ck_i,       // clock sample to pass
	input  wire logic [1:0] level_i,    // static level field
	output logic            ck_o        // gated output
);
	ckr_lvl_state_t state_reg;
	logic           val_reg;
	logic           ck_prev_reg;

	// ----------------------------------------------------------------
	// glitch-free entry, and exit from held low to normal
	// ----------------------------------------------------------------
	// entry waits until the clock already sits at the target level, exit first loads bit 1 of the
	// new level field into the output, then waits until the clock matches it, so leaving held high for 00 drops the output at once
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_reg   <= LV_PASS;
			val_reg     <= 1'b0;
			ck_prev_reg <= 1'b0;
		end
		else
		begin
			ck_prev_reg <= ck_i;
			case (state_reg)
				LV_PASS:
				begin
					val_reg <= ck_i;
					if (level_i == LVL_LOW || level_i == LVL_HIGH)
					begin
						state_reg <= LV_WAIT;
						val_reg   <= ck_prev_reg;
					end
				end
				LV_WAIT:
				begin
					// an aborted entry leaves like a normal exit so the held level is not cut
					if (level_i != LVL_LOW && level_i != LVL_HIGH)
						state_reg <= LV_LEAVE; // RULE4
					else if (ck_prev_reg == level_i[1])
					begin
						state_reg <= LV_HOLD; // RULE4
						val_reg   <= level_i[1];
					end
				end
				LV_HOLD:
				begin
					val_reg <= level_i[1]; // RULE2 RULE3
					if (level_i != LVL_LOW && level_i != LVL_HIGH)
						state_reg <= LV_LEAVE;
				end
				LV_LEAVE:
				begin
					if (ck_i == val_reg)
					begin
						state_reg <= LV_PASS; // RULE4
						val_reg   <= ck_i;
					end
				end
				default: state_reg <= LV_PASS;
			endcase
		end
	end

	assign ck_o = val_reg;

	a_lvl_hold_value : assert property (@(posedge clk_i) disable iff (reset_i) // RULE3
		(state_reg == LV_HOLD && $past(state_reg) == LV_HOLD && level_i == LVL_LOW
			&& $past(level_i) == LVL_LOW) |-> !ck_o)
		else $error("forced low output not low");
	a_lvl_no_runt : assert property (@(posedge clk_i) disable iff (reset_i) // RULE4
		($past(state_reg) == LV_WAIT && state_reg == LV_HOLD) |=> $stable(ck_o))
		else $error("output toggled on entry to forced level");

endmodule : ckr_level_force

// *** logic/ckr_regs.sv ***
// Notes on behaviour
// [RULE1] Alarm reference field picks crystal at 000, input one at 001, input two at 010.
// [RULE2] Output two level field: 00 normal, 01 held low, 10 held high, 11 reserved.
// [RULE3] Output one level field: 00 normal, 01 held low, 10 held high, 11 reserved.
// [RULE4] Entering or leaving a forced level makes no glitch or runt pulse. Leaving held high for 00 here drops the output at once.
// [RULE5] Bits 7:3 of the averaging register set the holdover history averaging time.
// [RULE6] Bit 3 set powers down output two buffer and its low-speed divider.
// [RULE7] Bit 2 set powers down output one buffer and its low-speed divider.
// [RULE8] Bit 1 set powers down the input two buffer.
// [RULE9] Bit 0 set powers down the input one buffer.
// [RULE10] With pin stepping off the coarse phase register sets a signed delay in oscillator periods.
// [RULE11] A coarse phase change may take up to 20 seconds to settle.
// [RULE12] With the high-speed divider at 000 an increase of coarse phase is not applied.
// [RULE13] Forcing digital hold overrides selection and uses the averaged history.
// [RULE14] Reserved bits are read-only and ignore writes.
`timescale 1ns/1ps
module ckr_regs
	import ckr_pkg::*;
#(
	parameter longint SETTLE_CYC = PHASE_SETTLE_CYC
)
(
	input  wire logic       clk_i,                 // system clock
	input  wire logic       reset_i,               // sync reset, active high
	input  wire logic [7:0] addr_i,                // register offset
	input  wire logic       wr_i,                  // write strobe
	input  wire logic [7:0] wdata_i,               // write data
	output logic      [7:0] rdata_o,               // read data
	input  wire logic       pin_phase_step_control_i, // pin stepping active
	input  wire logic [2:0] high_speed_divider_setting_i, // high-speed divider
	input  wire logic       digital_hold_force_i,  // force digital hold
	input  wire logic       ck_one_i,              // output one raw clock
	input  wire logic       ck_two_i,              // output two raw clock
	output logic            clock_output_one_o,    // output one after forcing
	output logic            clock_output_two_o,    // output two after forcing
	output logic      [2:0] offset_alarm_reference_select_o, // alarm reference
	output logic            alarm_ref_crystal_o,   // crystal is reference
	output logic            alarm_ref_in_one_o,    // input one is reference
	output logic            alarm_ref_in_two_o,    // input two is reference
	output logic      [4:0] holdover_average_time_o, // history averaging
	output logic            history_use_o,         // digital hold active
	output logic            out_one_buffer_off_o,  // output one buffer off
	output logic            out_two_buffer_off_o,  // output two buffer off
	output logic            out_one_low_speed_divider_off_o, // divider one off
	output logic            out_two_low_speed_divider_off_o, // divider two off
	output logic            in_one_buffer_off_o,   // input one buffer off
	output logic            in_two_buffer_off_o,   // input two buffer off
	output logic      [7:0] coarse_output_phase_o, // applied phase, signed
	output logic            phase_settling_o       // phase change in progress
);

	logic [7:0] alarm_ref_reg;
	logic [7:0] lvl_reg;
	logic [7:0] avg_reg;
	logic [7:0] opd_reg;
	logic [7:0] ipd_reg;
	logic [7:0] ph_reg;
	logic [7:0] ph_applied_reg;
	logic [7:0] ph_applied_next;
	logic [35:0] settle_reg;

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
		input logic [7:0] wm);
		merge = (old & ~wm) | (wd & wm); // RULE14
	endfunction : merge

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			alarm_ref_reg <= RST_ALARM_REF;
			lvl_reg       <= RST_STATIC_LVL;
			avg_reg       <= RST_HOLD_AVG;
			opd_reg     <= RST_OUT_PD;
			ipd_reg     <= RST_IN_PD;
			ph_reg      <= RST_COARSE_PH;
		end
		else if (wr_i)
		begin
			case (addr_i)
				OFS_ALARM_REF:  alarm_ref_reg <= merge(alarm_ref_reg, wdata_i, WM_ALARM_REF);
				OFS_STATIC_LVL: lvl_reg     <= merge(lvl_reg, wdata_i, WM_STATIC_LVL);
				OFS_HOLD_AVG:   avg_reg     <= merge(avg_reg, wdata_i, WM_HOLD_AVG);
				OFS_OUT_PD:     opd_reg     <= merge(opd_reg, wdata_i, WM_OUT_PD);
				OFS_IN_PD:      ipd_reg     <= merge(ipd_reg, wdata_i, WM_IN_PD);
				OFS_COARSE_PH:  ph_reg      <= wdata_i;
				default:        ph_reg      <= ph_reg;
			endcase
		end
	end

	always_comb
	begin
		case (addr_i)
			OFS_ALARM_REF:  rdata_o = alarm_ref_reg;
			OFS_STATIC_LVL: rdata_o = lvl_reg;
			OFS_HOLD_AVG:   rdata_o = avg_reg;
			OFS_OUT_PD:     rdata_o = opd_reg;
			OFS_IN_PD:      rdata_o = ipd_reg;
			OFS_COARSE_PH:  rdata_o = ph_reg;
			default:        rdata_o = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// alarm reference, averaging, power-down
	// ----------------------------------------------------------------
	assign offset_alarm_reference_select_o = alarm_ref_reg[2:0];
	assign alarm_ref_crystal_o = (alarm_ref_reg[2:0] == REF_SEL_CRYSTAL); // RULE1
	assign alarm_ref_in_one_o  = (alarm_ref_reg[2:0] == REF_SEL_IN_ONE);  // RULE1
	assign alarm_ref_in_two_o  = (alarm_ref_reg[2:0] == REF_SEL_IN_TWO);  // RULE1
	assign holdover_average_time_o = avg_reg[HOLD_AVG_LSB +: 5]; // RULE5
	assign history_use_o = digital_hold_force_i; // RULE13
	assign out_two_buffer_off_o            = opd_reg[OUT_TWO_OFF_BIT]; // RULE6
	assign out_two_low_speed_divider_off_o = opd_reg[OUT_TWO_OFF_BIT]; // RULE6
	assign out_one_buffer_off_o            = opd_reg[OUT_ONE_OFF_BIT]; // RULE7
	assign out_one_low_speed_divider_off_o = opd_reg[OUT_ONE_OFF_BIT]; // RULE7
	assign in_two_buffer_off_o = ipd_reg[IN_TWO_OFF_BIT]; // RULE8
	assign in_one_buffer_off_o = ipd_reg[IN_ONE_OFF_BIT]; // RULE9

	// ----------------------------------------------------------------
	// static level forcing
	// ----------------------------------------------------------------
	ckr_level_force u_force_one (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ck_i    (ck_one_i),
		.level_i (lvl_reg[OUT_ONE_LVL_LSB +: 2]), // RULE3
		.ck_o    (clock_output_one_o)
	);

	ckr_level_force u_force_two (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ck_i    (ck_two_i),
		.level_i (lvl_reg[OUT_TWO_LVL_LSB +: 2]), // RULE2
		.ck_o    (clock_output_two_o)
	);

	// ----------------------------------------------------------------
	// coarse phase
	// ----------------------------------------------------------------
	// pin stepping owns the phase while active, so the register is not applied
	always_comb
	begin
		ph_applied_next = ph_applied_reg;
		if (!pin_phase_step_control_i && ph_reg != ph_applied_reg) // RULE10
		begin
			if (high_speed_divider_setting_i == HS_DIV_ZERO
				&& $signed(ph_reg) > $signed(ph_applied_reg))
				ph_applied_next = ph_applied_reg; // RULE12
			else
				ph_applied_next = ph_reg; // RULE10
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			ph_applied_reg <= RST_COARSE_PH;
		else
			ph_applied_reg <= ph_applied_next;
	end

	// settling window the host must respect after a change
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			settle_reg <= 36'h0;
		else if (ph_applied_next != ph_applied_reg)
			settle_reg <= SETTLE_CYC[35:0]; // RULE11
		else if (settle_reg != 36'h0)
			settle_reg <= settle_reg - 36'h1;
	end

	assign coarse_output_phase_o = ph_applied_reg;
	assign phase_settling_o = (settle_reg != 36'h0);

	a_reserved_ro : assert property (@(posedge clk_i) disable iff (reset_i) // RULE14
		(wr_i && addr_i == OFS_OUT_PD) |=> (opd_reg[7:4] == 4'h0 && opd_reg[1:0] == 2'h0))
		else $error("reserved bits changed");
	a_no_increase : assert property (@(posedge clk_i) disable iff (reset_i) // RULE12
		(high_speed_divider_setting_i == HS_DIV_ZERO && $signed(ph_reg) > $signed(ph_applied_reg))
		|=> $stable(coarse_output_phase_o))
		else $error("phase increased with divider zero");
	a_phase_apply : assert property (@(posedge clk_i) disable iff (reset_i) // RULE10
		(!pin_phase_step_control_i && high_speed_divider_setting_i != HS_DIV_ZERO)
		|=> coarse_output_phase_o == $past(ph_reg))
		else $error("coarse phase not applied");
	a_pin_hold : assert property (@(posedge clk_i) disable iff (reset_i) // RULE10
		pin_phase_step_control_i |=> $stable(coarse_output_phase_o))
		else $error("phase changed under pin stepping");
	a_settle_start : assert property (@(posedge clk_i) disable iff (reset_i) // RULE11
		(ph_applied_next != ph_applied_reg) |=> ##[0:2] phase_settling_o)
		else $error("settling not flagged");
	a_pd_out_two : assert property (@(posedge clk_i) disable iff (reset_i) // RULE6
		(wr_i && addr_i == OFS_OUT_PD) |=> (out_two_buffer_off_o == $past(wdata_i[3])
			&& out_two_low_speed_divider_off_o == out_two_buffer_off_o))
		else $error("output two powerdown wrong");
	a_pd_in_one : assert property (@(posedge clk_i) disable iff (reset_i) // RULE9
		(wr_i && addr_i == OFS_IN_PD) |=> in_one_buffer_off_o == $past(wdata_i[0]))
		else $error("input one powerdown wrong");
	a_avg_field : assert property (@(posedge clk_i) disable iff (reset_i) // RULE5
		(wr_i && addr_i == OFS_HOLD_AVG) |=> holdover_average_time_o == $past(wdata_i[7:3]))
		else $error("averaging field wrong");

endmodule : ckr_regs

// *** sim/test_ckr_regs.sv ***
`timescale 1ns/1ps
module test_ckr_regs
	import ckr_pkg::*;
;
	localparam int SETTLE = 50;
	logic       clk_i = 1'b0;
	logic       reset_i;
	logic [7:0] addr_i;
	logic       wr_i;
	logic [7:0] wdata_i;
	logic       pin_i;
	logic [2:0] div_i;
	logic       hold_i;
	logic       ck_one_i = 1'b0;
	logic       ck_two_i = 1'b1;
	logic [1:0] dv = 2'h0;
	logic [7:0] rdata_o;
	logic [2:0] sel_o;
	logic [4:0] avg_o;
	logic [7:0] ph_o;
	logic       o1, o2, xtal, r1, r2, hist, ob1, ob2, od1, od2, ib1, ib2, settl, cur;
	logic [7:0] run[2];
	logic [1:0] seen[2];
	logic       last[2];
	int         n_mismatch = 0;
	int         checks_done = 0;
	logic [7:0] ofs[6] = '{OFS_ALARM_REF, OFS_STATIC_LVL, OFS_HOLD_AVG, OFS_OUT_PD, OFS_IN_PD,
		OFS_COARSE_PH};
	logic [7:0] rst[6] = '{RST_ALARM_REF, RST_STATIC_LVL, RST_HOLD_AVG, RST_OUT_PD, RST_IN_PD,
		RST_COARSE_PH};
	logic [7:0] wm[6] = '{WM_ALARM_REF, WM_STATIC_LVL, WM_HOLD_AVG, WM_OUT_PD, WM_IN_PD,
		WM_COARSE_PH};
	logic [1:0] lv[6] = '{LVL_LOW, LVL_NORMAL, LVL_HIGH, LVL_NORMAL, 2'h3, LVL_NORMAL};

	ckr_regs #(.SETTLE_CYC(SETTLE)) i_dut (
		.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wr_i(wr_i), .wdata_i(wdata_i),
		.rdata_o(rdata_o), .pin_phase_step_control_i(pin_i), .high_speed_divider_setting_i(div_i),
		.digital_hold_force_i(hold_i), .ck_one_i(ck_one_i), .ck_two_i(ck_two_i),
		.clock_output_one_o(o1), .clock_output_two_o(o2), .offset_alarm_reference_select_o(sel_o),
		.alarm_ref_crystal_o(xtal), .alarm_ref_in_one_o(r1), .alarm_ref_in_two_o(r2),
		.holdover_average_time_o(avg_o), .history_use_o(hist), .out_one_buffer_off_o(ob1),
		.out_two_buffer_off_o(ob2), .out_one_low_speed_divider_off_o(od1),
		.out_two_low_speed_divider_off_o(od2), .in_one_buffer_off_o(ib1),
		.in_two_buffer_off_o(ib2), .coarse_output_phase_o(ph_o), .phase_settling_o(settl));

	// ----------------------------------------------------------------
	// clocks and output pulse watch
	// ----------------------------------------------------------------
	always #5 clk_i = ~clk_i;

	// raw clocks of half period 4 so any runt shows as a run shorter than 4
	always @(posedge clk_i)
	begin
		dv <= dv + 2'h1;
		if (dv == 2'h3)
		begin
			ck_one_i <= ~ck_one_i;
			ck_two_i <= ck_one_i;
		end
	end

	always @(negedge clk_i)
	begin
		for (int k = 0; k < 2; k++)
		begin
			cur = k ? o2 : o1;
			if (reset_i)
			begin
				seen[k] = 2'h0;
				last[k] = cur;
				run[k] = 8'h00;
			end
			else if (cur !== last[k])
			begin
				// the first two runs after reset start mid-phase of the raw clock, so judge later ones
				if (seen[k] == 2'h2)
					chk("pulse_len", 8'h01, {7'h0, run[k] >= 8'h04});
				else
					seen[k] = seen[k] + 2'h1;
				last[k] = cur;
				run[k] = 8'h01;
			end
			else if (run[k] != 8'hff)
				run[k] = run[k] + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(negedge clk_i);
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_i);
		addr_i <= a;
		@(negedge clk_i);
		v = rdata_o;
	endtask : rd

	task ph(input logic [7:0] d, input logic [7:0] e);
		wr(OFS_COARSE_PH, d);
		repeat (2) @(negedge clk_i);
		chk("phase", e, ph_o);
		repeat (40) @(negedge clk_i);
		if (d === e)
			chk("settling_on", 8'h01, {7'h0, settl});
		repeat (15) @(negedge clk_i);
		chk("settling_off", 8'h00, {7'h0, settl});
	endtask : ph

	task end_of_test;
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs;
		logic [7:0] v;
		for (int i = 0; i < 6; i++)
		begin
			rd(ofs[i], v);
			chk("reset_value", rst[i], v);
			wr(ofs[i], 8'hff);
			rd(ofs[i], v);
			chk("write_ones", (rst[i] & ~wm[i]) | wm[i], v);
			wr(ofs[i], 8'h00);
			rd(ofs[i], v);
			chk("write_zeros", rst[i] & ~wm[i], v);
		end
		wr(8'h0c, 8'h5a);
		rd(8'h0c, v);
		chk("unmapped", 8'h00, v);
	endtask : t_regs

	task t_fields;
		for (int c = 0; c < 4; c++)
		begin
			wr(OFS_ALARM_REF, 8'(c));
			chk("ref_sel", 8'(c), {5'h0, sel_o});
			chk("ref_dec", {5'h0, c == 2, c == 1, c == 0}, {5'h0, r2, r1, xtal});
			wr(OFS_OUT_PD, 8'(c << 2));
			chk("out_off", {4'h0, c[1], c[1], c[0], c[0]}, {4'h0, ob2, od2, ob1, od1});
			wr(OFS_IN_PD, 8'(c));
			chk("in_off", 8'(c), {6'h0, ib2, ib1});
		end
		wr(OFS_HOLD_AVG, 8'ha8);
		chk("avg_time", 8'h15, {3'h0, avg_o});
		@(posedge clk_i) hold_i <= 1'b1;
		@(negedge clk_i) chk("hold_on", 8'h01, {7'h0, hist});
		@(posedge clk_i) hold_i <= 1'b0;
		@(negedge clk_i) chk("hold_off", 8'h00, {7'h0, hist});
	endtask : t_fields

	task t_level;
		logic [7:0] n1, n2, e;
		for (int i = 0; i < 6; i++)
		begin
			wr(OFS_STATIC_LVL, {lv[i], lv[i], 4'h0});
			repeat (12) @(negedge clk_i);
			n1 = 8'h00;
			n2 = 8'h00;
			repeat (8)
			begin
				@(negedge clk_i);
				n1 = n1 + {7'h0, o1};
				n2 = n2 + {7'h0, o2};
			end
			e = (lv[i] == LVL_LOW) ? 8'h00 : (lv[i] == LVL_HIGH) ? 8'h08 : 8'h04;
			chk("out_one_highs", e, n1);
			chk("out_two_highs", e, n2);
		end
	endtask : t_level

	task t_phase;
		ph(8'h7f, 8'h7f);
		ph(8'h80, 8'h80);
		ph(8'h10, 8'h10);
		@(posedge clk_i) div_i <= HS_DIV_ZERO;
		ph(8'h20, 8'h10);
		ph(8'h08, 8'h08);
		@(posedge clk_i) div_i <= 3'h1;
		ph(8'h20, 8'h20);
		@(posedge clk_i) pin_i <= 1'b1;
		ph(8'h30, 8'h20);
	endtask : t_phase

	initial
	begin
		reset_i = 1'b1;
		addr_i = 8'h00;
		wr_i = 1'b0;
		wdata_i = 8'h00;
		pin_i = 1'b0;
		div_i = 3'h1;
		hold_i = 1'b0;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		t_regs();
		t_fields();
		t_level();
		t_phase();
		end_of_test();
	end

	// whole run is near 624 cycles
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		end_of_test();
	end
endmodule : test_ckr_regs
